// file: include/spp_pkg.sv
package spp_pkg;
  localparam int SECT_MAX = 24;
  localparam int SP_LO    = -1999;
  localparam int SP_HI    = 9999;
  localparam int PAR_HI   = 9999;
  localparam int GAP_HI   = 999;
  localparam int TRV_LO   = 5;
  localparam int TRV_HI   = 3000;
  localparam int OFS_LO   = -100;
  localparam int OFS_HI   = 100;
  localparam int PCT      = 100;
  localparam int PB_RST   = 0;
  localparam int DT_RST   = 80;
  localparam int IT_RST   = 350;
  localparam int SW_RST   = 20;
  localparam int GAP_RST  = 0;
  localparam int HYS_RST  = 1;
  localparam int TRV_RST  = 60;
  localparam int OFS_RST  = 0;
  localparam int TICK_MS  = 150;
  localparam int CLK_KHZ  = 125000;
  localparam int TICK_CYC = TICK_MS * CLK_KHZ;

  typedef enum logic [2:0] {
    SPP_P   = 3'h0,
    SPP_I   = 3'h1,
    SPP_PI  = 3'h2,
    SPP_PD  = 3'h3,
    SPP_PID = 3'h4
  } spp_struct_t;

  typedef enum logic [1:0] {
    SPP_TWO_STATE   = 2'h0,
    SPP_THREE_STATE = 2'h1,
    SPP_THREE_STEP  = 2'h2,
    SPP_CONTINUOUS  = 2'h3
  } spp_ctype_t;

  typedef struct packed {
    logic signed [15:0] setpoint;
    logic [15:0]        duration;
    logic [3:0]         contacts;
  } spp_sect_t;

  typedef struct packed {
    spp_struct_t       struct_first;
    spp_struct_t       struct_second;
    logic [13:0]       prop_band_first;
    logic [13:0]       prop_band_second;
    logic [13:0]       deriv_time_first;
    logic [13:0]       deriv_time_second;
    logic [13:0]       integral_time_first;
    logic [13:0]       integral_time_second;
    logic [13:0]       switch_period_first;
    logic [13:0]       switch_period_second;
    logic [9:0]        contact_gap;
    logic [9:0]        hysteresis_first;
    logic [9:0]        hysteresis_second;
    logic [11:0]       valve_travel_time;
    logic signed [7:0] output_offset_point;
  } spp_pblk_t;

  localparam spp_pblk_t PBLK_RST = '{
    SPP_P, SPP_P, 14'(PB_RST), 14'(PB_RST), 14'(DT_RST), 14'(DT_RST),
    14'(IT_RST), 14'(IT_RST), 14'(SW_RST), 14'(SW_RST), 10'(GAP_RST),
    10'(HYS_RST), 10'(HYS_RST), 12'(TRV_RST), 8'(OFS_RST)};
endpackage

// file: src/spp_sect_mem.sv
`timescale 1ns/10ps
module spp_sect_mem #(
  parameter int DEPTH = spp_pkg::SECT_MAX,
  parameter int AW    = 5
) (
  input  wire logic                clk_sys_in,
  input  wire logic                reset_in,
  input  wire logic                wr_en_in,
  input  wire logic [AW-1:0]       wr_addr_in,
  input  wire spp_pkg::spp_sect_t  wr_data_in,
  input  wire logic [AW-1:0]       rd_addr_in,
  output spp_pkg::spp_sect_t       rd_data_out
);
  spp_pkg::spp_sect_t mem_q [DEPTH];

  always_ff @(posedge clk_sys_in) begin
    if (wr_en_in && int'(wr_addr_in) < DEPTH) begin
      mem_q[wr_addr_in] <= wr_data_in;
    end
  end

  // Reads during reset or at addresses of DEPTH or more return an all-zero section.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in || int'(rd_addr_in) >= DEPTH) begin
      rd_data_out <= '0;
    end else begin
      rd_data_out <= mem_q[rd_addr_in];
    end
  end
endmodule

// file: src/spp_setpoint_gen.sv
// Overview of operation
// R1: four contacts follow each section's activation flags
// R2: section start takes its programmed setpoint
// R3: step mode holds setpoint through section
// R4: ramp mode slopes toward next section value
// R5: equal next setpoint gives flat ramp
// R6: two identical blocks, irrelevant fields ignored
// R7: structure selectors for first and second outputs
// R8: band 0..9999, zero means limit monitoring
// R9: continuous controller never uses zero-band fallback
// R10: derivative time 0..9999, default 80
// R11: reset time 0..9999, default 350
// R12: cycle time 0..9999, default 20
// R13: contact spacing 0..999, default 0
// R14: hysteresis 0..999, default 1, zero band
// R15: actuator time 5..3000, default 60
// R16: working point -100..100 offsets output level
// R17: zero error gives working point output
// R18: up to 24 sections, ascending from first
// R19: setpoints bounded -1999..9999 and configured limits
// R20: ramp recomputed each tick by interpolation
`timescale 1ns/10ps
module spp_setpoint_gen #(
  parameter int TICK_CYC = spp_pkg::TICK_CYC,
  parameter int SECT_MAX = spp_pkg::SECT_MAX
) (
  input  wire logic               clk_sys_in,
  input  wire logic               reset_in,
  input  wire logic               sect_wr_in,
  input  wire logic [4:0]         sect_idx_in,
  input  wire spp_pkg::spp_sect_t sect_data_in,
  input  wire logic [4:0]         sect_count_in,
  input  wire logic signed [15:0] sp_min_in,
  input  wire logic signed [15:0] sp_max_in,
  input  wire logic               ramp_mode_in,
  input  wire logic               start_in,
  input  wire logic               stop_in,
  input  wire logic               pblk_wr_in,
  input  wire logic               pblk_wr_sel_in,
  input  wire spp_pkg::spp_pblk_t pblk_data_in,
  input  wire logic               pblk_use_in,
  input  wire spp_pkg::spp_ctype_t ctype_in,
  input  wire logic signed [15:0] actual_in,
  output logic signed [15:0]      setpoint_out,
  output logic [3:0]              contacts_out,
  output logic [4:0]              section_out,
  output logic                    running_out,
  output logic signed [7:0]       level_out,
  output logic                    sw_first_out,
  output logic                    sw_second_out,
  output spp_pkg::spp_pblk_t      pblk_out
);
  localparam int TW = $clog2(TICK_CYC + 1);
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_RDCUR = 3'h1,
    ST_RDNXT = 3'h2,
    ST_LATCH = 3'h3,
    ST_RUN   = 3'h4,
    ST_DONE  = 3'h5
  } spp_state_t;
  function automatic int clampi(input int v, input int lo, input int hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction
  function automatic logic signed [15:0] interp(input logic signed [15:0] a,
                                                input logic signed [15:0] b,
                                                input logic [16:0] el,
                                                input logic [15:0] dur);
    int d;
    d = 0;
    if (dur != 16'h0000) begin
      d = ((int'(b) - int'(a)) * int'(el)) / int'(dur);
    end
    return 16'(int'(a) + d);
  endfunction
  // Every written field is forced into its legal range on entry.
  function automatic spp_pkg::spp_pblk_t sanitize(input spp_pkg::spp_pblk_t p);
    spp_pkg::spp_pblk_t r;
    r = p;
    r.prop_band_first      = 14'(clampi(int'(p.prop_band_first), 0, spp_pkg::PAR_HI));
    r.prop_band_second     = 14'(clampi(int'(p.prop_band_second), 0, spp_pkg::PAR_HI));
    r.deriv_time_first     = 14'(clampi(int'(p.deriv_time_first), 0, spp_pkg::PAR_HI));
    r.deriv_time_second    = 14'(clampi(int'(p.deriv_time_second), 0, spp_pkg::PAR_HI));
    r.integral_time_first  = 14'(clampi(int'(p.integral_time_first), 0, spp_pkg::PAR_HI));
    r.integral_time_second = 14'(clampi(int'(p.integral_time_second), 0, spp_pkg::PAR_HI));
    r.switch_period_first  = 14'(clampi(int'(p.switch_period_first), 0, spp_pkg::PAR_HI));
    r.switch_period_second = 14'(clampi(int'(p.switch_period_second), 0, spp_pkg::PAR_HI));
    r.contact_gap          = 10'(clampi(int'(p.contact_gap), 0, spp_pkg::GAP_HI));
    r.hysteresis_first     = 10'(clampi(int'(p.hysteresis_first), 0, spp_pkg::GAP_HI));
    r.hysteresis_second    = 10'(clampi(int'(p.hysteresis_second), 0, spp_pkg::GAP_HI));
    r.valve_travel_time    = 12'(clampi(int'(p.valve_travel_time), spp_pkg::TRV_LO,
                                        spp_pkg::TRV_HI));
    r.output_offset_point  = 8'(clampi(int'(p.output_offset_point), spp_pkg::OFS_LO,
                                       spp_pkg::OFS_HI));
    if (p.struct_first > spp_pkg::SPP_PID) begin
      r.struct_first = spp_pkg::SPP_PID;
    end
    if (p.struct_second > spp_pkg::SPP_PID) begin
      r.struct_second = spp_pkg::SPP_PID;
    end
    return r;
  endfunction
  // Fields that the configured controller type does not use read as zero.
  function automatic spp_pkg::spp_pblk_t relevant(input spp_pkg::spp_pblk_t p,
                                                  input spp_pkg::spp_ctype_t t);
    spp_pkg::spp_pblk_t r;
    r = p;
    if (t != spp_pkg::SPP_THREE_STATE) begin
      r.struct_second        = spp_pkg::SPP_P;
      r.prop_band_second     = '0;
      r.deriv_time_second    = '0;
      r.integral_time_second = '0;
      r.switch_period_second = '0;
      r.hysteresis_second    = '0;
    end
    if (t == spp_pkg::SPP_TWO_STATE || t == spp_pkg::SPP_CONTINUOUS) begin
      r.contact_gap = '0;
    end
    if (t != spp_pkg::SPP_THREE_STEP) begin
      r.valve_travel_time = '0;
    end
    // A continuous controller has no monitoring fallback, so a zero band acts as one.
    if (t == spp_pkg::SPP_CONTINUOUS && p.prop_band_first == '0) begin
      r.prop_band_first = 14'h0001; // R9
    end
    return r;
  endfunction
  spp_state_t         state_q;
  logic [4:0]         idx_q;
  logic [15:0]        el_q;
  logic [TW-1:0]      tick_cnt_q;
  logic               tick_q;
  spp_pkg::spp_sect_t cur_q;
  spp_pkg::spp_sect_t nxt_q;
  spp_pkg::spp_sect_t rd_data;
  spp_pkg::spp_sect_t wr_ent;
  spp_pkg::spp_pblk_t blk_q [2];
  logic [4:0]         cnt_w;
  logic [4:0]         rd_addr;
  logic [16:0]        el_nx;
  logic               sect_end;
  logic               more;
  logic signed [15:0] ramp_w;
  int                 sp_lo;
  int                 sp_hi;
  int                 err;
  int                 pb_use;
  int                 lvl_w;
  assign cnt_w    = (int'(sect_count_in) > SECT_MAX) ? 5'(SECT_MAX) : sect_count_in; // R18
  assign rd_addr  = (state_q == ST_RDCUR) ? idx_q : 5'(idx_q + 5'h01);
  assign el_nx    = {1'b0, el_q} + 17'h00001;
  assign sect_end = el_nx >= {1'b0, cur_q.duration};
  assign more     = (idx_q + 5'h01) < cnt_w;
  assign ramp_w   = interp(cur_q.setpoint, nxt_q.setpoint, el_nx, cur_q.duration); // R20
  assign sp_lo    = (int'(sp_min_in) > spp_pkg::SP_LO) ? int'(sp_min_in) : spp_pkg::SP_LO;
  assign sp_hi    = (int'(sp_max_in) < spp_pkg::SP_HI) ? int'(sp_max_in) : spp_pkg::SP_HI;
  always_comb begin
    wr_ent          = sect_data_in;
    wr_ent.setpoint = 16'(clampi(int'(sect_data_in.setpoint), sp_lo, sp_hi)); // R19
  end
  spp_sect_mem #(
    .DEPTH (SECT_MAX),
    .AW    (5)
  ) u_mem (
    .clk_sys_in  (clk_sys_in),
    .reset_in    (reset_in),
    .wr_en_in    (sect_wr_in),
    .wr_addr_in  (sect_idx_in),
    .wr_data_in  (wr_ent),
    .rd_addr_in  (rd_addr),
    .rd_data_out (rd_data)
  );
  // Sampling tick: all setpoint time is counted in these ticks.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in || tick_cnt_q == TW'(TICK_CYC - 1)) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + TW'(1);
    end
  end
  always_ff @(posedge clk_sys_in) begin
    tick_q <= !reset_in && tick_cnt_q == TW'(TICK_CYC - 1);
  end
  always_ff @(posedge clk_sys_in) begin
    if (reset_in || stop_in) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE, ST_DONE: begin
          if (start_in && cnt_w != 5'h00) begin
            state_q <= ST_RDCUR;
          end
        end
        ST_RDCUR: state_q <= ST_RDNXT;
        ST_RDNXT: state_q <= ST_LATCH;
        ST_LATCH: state_q <= ST_RUN;
        ST_RUN: begin
          if (tick_q && sect_end) begin
            state_q <= more ? ST_RDCUR : ST_DONE; // R18
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      idx_q <= '0;
    end else if ((state_q == ST_IDLE || state_q == ST_DONE) && start_in) begin
      idx_q <= '0; // R18
    end else if (state_q == ST_RUN && tick_q && sect_end && more) begin
      idx_q <= idx_q + 5'h01; // R18
    end
  end
  // The next section's value is needed for the ramp; the last section ramps to itself.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      cur_q <= '0;
      nxt_q <= '0;
    end else if (state_q == ST_RDNXT) begin
      cur_q <= rd_data;
    end else if (state_q == ST_LATCH) begin
      nxt_q <= more ? rd_data : cur_q;
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (reset_in || state_q == ST_LATCH) begin
      el_q <= '0;
    end else if (state_q == ST_RUN && tick_q) begin
      el_q <= el_nx[15:0];
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      setpoint_out <= '0;
    end else if (state_q == ST_LATCH) begin
      setpoint_out <= cur_q.setpoint; // R2
    end else if (state_q == ST_RUN && tick_q && !sect_end) begin
      setpoint_out <= ramp_mode_in ? ramp_w : cur_q.setpoint; // R3 R4 R5
    end
  end
  // Contacts of a finished section stay on for the three fetch cycles of the next one.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in || state_q == ST_IDLE || state_q == ST_DONE) begin
      contacts_out <= '0;
    end else if (state_q == ST_LATCH) begin
      contacts_out <= cur_q.contacts; // R1
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      section_out <= '0;
      running_out <= 1'b0;
    end else begin
      section_out <= idx_q;
      running_out <= state_q != ST_IDLE && state_q != ST_DONE;
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      blk_q[0] <= spp_pkg::PBLK_RST; // R8 R10 R11 R12 R13 R14 R15 R16
      blk_q[1] <= spp_pkg::PBLK_RST;
    end else if (pblk_wr_in) begin
      blk_q[pblk_wr_sel_in] <= sanitize(pblk_data_in); // R6 R7
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      pblk_out <= spp_pkg::PBLK_RST;
    end else begin
      pblk_out <= relevant(blk_q[pblk_use_in], ctype_in); // R6
    end
  end
  // Output level: working point plus proportional share; integral and derivative
  // terms are left to downstream logic that reads pblk_out.
  always_comb begin
    err    = int'(setpoint_out) - int'(actual_in);
    pb_use = int'(pblk_out.prop_band_first);
    if (ctype_in == spp_pkg::SPP_THREE_STATE && err < 0) begin
      pb_use = int'(pblk_out.prop_band_second); // R7
    end
    lvl_w = int'(pblk_out.output_offset_point); // R16
    if (pb_use != 0 && pblk_out.struct_first != spp_pkg::SPP_I) begin
      lvl_w = lvl_w + (err * spp_pkg::PCT) / pb_use; // R7 R17
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      level_out <= '0;
    end else begin
      level_out <= 8'(clampi(lvl_w, -spp_pkg::PCT, spp_pkg::PCT));
    end
  end
  // Limit monitoring with zero band; turn-on is tested first so it wins over turn-off.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in || pblk_out.prop_band_first != '0 ||
        ctype_in == spp_pkg::SPP_CONTINUOUS) begin
      sw_first_out <= 1'b0; // R8 R9
    end else if (err >= int'(pblk_out.hysteresis_first)) begin
      sw_first_out <= 1'b1; // R14
    end else if (err <= 0) begin
      sw_first_out <= 1'b0;
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (reset_in || pblk_out.prop_band_second != '0 ||
        ctype_in != spp_pkg::SPP_THREE_STATE) begin
      sw_second_out <= 1'b0;
    end else if (-err >= int'(pblk_out.contact_gap) + int'(pblk_out.hysteresis_second)) begin
      sw_second_out <= 1'b1; // R13 R14
    end else if (-err <= int'(pblk_out.contact_gap)) begin
      sw_second_out <= 1'b0;
    end
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  property p_contacts;
    (state_q == ST_RUN) |-> contacts_out == cur_q.contacts;
  endproperty
  a_contacts: assert property (p_contacts) else $error("contacts differ from section"); // R1
  property p_start_sp;
    (state_q == ST_LATCH) ##1 !stop_in |-> setpoint_out == $past(cur_q.setpoint);
  endproperty
  a_start_sp: assert property (p_start_sp) else $error("section start setpoint wrong"); // R2
  property p_step_hold;
    (state_q == ST_RUN && !ramp_mode_in) ##1 (state_q == ST_RUN) |-> $stable(setpoint_out);
  endproperty
  a_step_hold: assert property (p_step_hold) else $error("step setpoint moved"); // R3
  property p_ramp;
    (state_q == ST_RUN && ramp_mode_in && tick_q && !sect_end && !stop_in)
      |=> setpoint_out == $past(ramp_w);
  endproperty
  a_ramp: assert property (p_ramp) else $error("ramp value wrong"); // R4
  property p_flat;
    (state_q == ST_RUN && cur_q.setpoint == nxt_q.setpoint) ##1 (state_q == ST_RUN)
      |-> setpoint_out == cur_q.setpoint;
  endproperty
  a_flat: assert property (p_flat) else $error("flat section moved"); // R5
  property p_zero_err;
    (err == 0) |=> level_out == $past(pblk_out.output_offset_point);
  endproperty
  a_zero_err: assert property (p_zero_err) else $error("level not working point"); // R17
  property p_band_sw;
    (pblk_out.prop_band_first != '0) |=> !sw_first_out;
  endproperty
  a_band_sw: assert property (p_band_sw) else $error("switch active with band"); // R8
  property p_cont;
    (ctype_in == spp_pkg::SPP_CONTINUOUS) |=> pblk_out.prop_band_first != '0 && !sw_first_out;
  endproperty
  a_cont: assert property (p_cont) else $error("continuous uses zero band"); // R9
  property p_order;
    (state_q == ST_RUN && tick_q && sect_end && more && !stop_in)
      |=> idx_q == $past(idx_q) + 5'h01 ##3 state_q == ST_RUN;
  endproperty
  a_order: assert property (p_order) else $error("section order broken"); // R18
  property p_range;
    (state_q == ST_RUN) |-> int'(cur_q.setpoint) >= spp_pkg::SP_LO &&
                            int'(cur_q.setpoint) <= spp_pkg::SP_HI && idx_q < 5'(SECT_MAX);
  endproperty
  a_range: assert property (p_range) else $error("section out of range"); // R19
  c_ramp: cover property (state_q == ST_RUN && ramp_mode_in && tick_q && !sect_end);
  c_next: cover property (state_q == ST_RUN && tick_q && sect_end && more);
  c_done: cover property (state_q == ST_RUN ##1 state_q == ST_DONE);
  c_sw2:  cover property ($rose(sw_second_out));
endmodule

// file: tb/spp_plant.sv
`timescale 1ns/10ps
module spp_plant (
  input  wire logic               clk_sys_in,
  input  wire logic               hold_in,
  input  wire logic signed [15:0] hold_val_in,
  input  wire logic signed [7:0]  level_in,
  input  wire logic               sw_first_in,
  input  wire logic               sw_second_in,
  output logic signed [15:0]      actual_out
);
  // A held plant pins the measured value so that errors are exact; a free plant drifts with
  // the drive, which is coarse but keeps the control loop closed during program runs.
  always_ff @(posedge clk_sys_in) begin
    if (hold_in) begin
      actual_out <= hold_val_in;
    end else begin
      actual_out <= actual_out + 16'(level_in >>> 4) + 16'(sw_first_in) - 16'(sw_second_in);
    end
  end
endmodule

// file: tb/tb_spp_setpoint_gen.sv
`timescale 1ns/10ps
module tb_spp_setpoint_gen;
  typedef logic signed [15:0] spp_q_t[$];
  typedef logic [3:0] spp_cq_t[$];
  typedef struct {
    spp_pkg::spp_ctype_t ct;
    logic [13:0]         band;
    logic signed [7:0]   off;
    logic signed [15:0]  act;
    logic signed [7:0]   lvl;
    logic                sw1;
    logic                sw2;
  } spp_row_t;

  logic clk, reset, sect_wr, ramp_mode, start, stop, pblk_wr, pblk_sel, pblk_use, hold;
  logic [4:0] sect_idx, sect_count, section;
  logic signed [15:0] sp_min, sp_max, actual, hold_val, setpoint;
  logic [3:0] contacts;
  logic running, sw1, sw2;
  logic signed [7:0] level;
  spp_pkg::spp_sect_t sect_data;
  spp_pkg::spp_pblk_t pb, pblk;
  spp_pkg::spp_ctype_t ctype;
  int n_fail, n_compared;
  spp_row_t rows[11] = '{
    '{spp_pkg::SPP_CONTINUOUS, 14'h0032, 8'h00, 16'h0064, 8'h00, 1'b0, 1'b0},
    '{spp_pkg::SPP_CONTINUOUS, 14'h0032, 8'h0A, 16'h0064, 8'h0A, 1'b0, 1'b0},
    '{spp_pkg::SPP_CONTINUOUS, 14'h0032, 8'h00, 16'h0050, 8'h28, 1'b0, 1'b0},
    '{spp_pkg::SPP_CONTINUOUS, 14'h00C8, 8'hEC, 16'h0078, 8'hE2, 1'b0, 1'b0},
    '{spp_pkg::SPP_TWO_STATE, 14'h0000, 8'h05, 16'h0064, 8'h05, 1'b0, 1'b0},
    '{spp_pkg::SPP_TWO_STATE, 14'h0000, 8'h00, 16'h0061, 8'h00, 1'b1, 1'b0},
    '{spp_pkg::SPP_TWO_STATE, 14'h0000, 8'h00, 16'h0063, 8'h00, 1'b1, 1'b0},
    '{spp_pkg::SPP_TWO_STATE, 14'h0000, 8'h00, 16'h0064, 8'h00, 1'b0, 1'b0},
    '{spp_pkg::SPP_THREE_STATE, 14'h0000, 8'h00, 16'h006B, 8'h00, 1'b0, 1'b1},
    '{spp_pkg::SPP_THREE_STATE, 14'h0000, 8'h00, 16'h006A, 8'h00, 1'b0, 1'b1},
    '{spp_pkg::SPP_THREE_STATE, 14'h0000, 8'h00, 16'h0069, 8'h00, 1'b0, 1'b0}};

  spp_setpoint_gen #(.TICK_CYC(8)) dut (
    .clk_sys_in(clk), .reset_in(reset), .sect_wr_in(sect_wr), .sect_idx_in(sect_idx),
    .sect_data_in(sect_data), .sect_count_in(sect_count), .sp_min_in(sp_min),
    .sp_max_in(sp_max), .ramp_mode_in(ramp_mode), .start_in(start), .stop_in(stop),
    .pblk_wr_in(pblk_wr), .pblk_wr_sel_in(pblk_sel), .pblk_data_in(pb),
    .pblk_use_in(pblk_use), .ctype_in(ctype), .actual_in(actual), .setpoint_out(setpoint),
    .contacts_out(contacts), .section_out(section), .running_out(running),
    .level_out(level), .sw_first_out(sw1), .sw_second_out(sw2), .pblk_out(pblk));

  spp_plant plant (
    .clk_sys_in(clk), .hold_in(hold), .hold_val_in(hold_val), .level_in(level),
    .sw_first_in(sw1), .sw_second_in(sw2), .actual_out(actual));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("Compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // The caller raises and lowers the write strobe so back-to-back entries stay one burst.
  task automatic wsect(input logic [4:0] i, input logic [15:0] s, input logic [15:0] d,
                       input logic [3:0] c);
    sect_idx = i;
    sect_data = '{s, d, c};
    @(negedge clk);
  endtask

  task automatic set_pb(input logic s, input spp_pkg::spp_ctype_t c, input logic [2:0] st,
                        input logic [13:0] b, input logic [7:0] o, input logic [11:0] t);
    pb = spp_pkg::PBLK_RST;
    pb.struct_first = spp_pkg::spp_struct_t'(st);
    pb.struct_second = spp_pkg::spp_struct_t'(st);
    pb.prop_band_first = b;
    pb.prop_band_second = b;
    pb.hysteresis_first = 10'h003;
    pb.hysteresis_second = 10'h002;
    pb.contact_gap = 10'h005;
    pb.output_offset_point = o;
    pb.valve_travel_time = t;
    ctype = c;
    pblk_sel = s;
    pblk_wr = 1'b1;
    @(negedge clk);
    pblk_wr = 1'b0;
    repeat (4) @(negedge clk);
  endtask

  // Recording starts at the first nonzero contact set, which marks the first section's start.
  task automatic run(input logic rm, input logic [4:0] n, input spp_q_t esp, input spp_cq_t ect);
    spp_q_t sp;
    spp_cq_t ct;
    bit on;
    on = 1'b0;
    ramp_mode = rm;
    sect_count = n;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    for (int k = 0; k < 4000; k++) begin
      @(negedge clk);
      if (contacts !== 4'h0) on = 1'b1;
      if (on && (sp.size() == 0 || sp[$] !== setpoint)) sp.push_back(setpoint);
      if (on && (ct.size() == 0 || ct[$] !== contacts)) ct.push_back(contacts);
      if (on && running !== 1'b1) break;
    end
    check("sp steps", 32'(sp.size()), 32'(esp.size()));
    check("contact steps", 32'(ct.size()), 32'(ect.size()));
    for (int k = 0; k < esp.size() && k < sp.size(); k++) check("setpoint", sp[k], esp[k]);
    for (int k = 0; k < ect.size() && k < ct.size(); k++) check("contacts", ct[k], ect[k]);
    check("running", running, 1'b0);
  endtask

  initial begin
    {sect_wr, ramp_mode, start, stop, pblk_wr, pblk_sel, pblk_use} = '0;
    reset = 1'b1;
    hold = 1'b1;
    hold_val = 16'h0000;
    sect_idx = 5'h00;
    sect_count = 5'h03;
    sect_data = '0;
    sp_min = 16'hF831;
    sp_max = 16'h270F;
    ctype = spp_pkg::SPP_CONTINUOUS;
    pb = spp_pkg::PBLK_RST;
    repeat (11) @(negedge clk);
    check("reset pblk", 32'(pblk === spp_pkg::PBLK_RST), 32'h1);
    check("reset running", running, 1'b0);
    check("reset contacts", contacts, 4'h0);
    @(negedge clk);
    reset = 1'b0;
    sect_wr = 1'b1;
    wsect(5'h00, 16'h0014, 16'h0002, 4'h1);
    wsect(5'h01, 16'h0064, 16'h0003, 4'h2);
    wsect(5'h02, 16'h0064, 16'h0001, 4'h4);
    sect_wr = 1'b0;
    set_pb(1'b0, spp_pkg::SPP_CONTINUOUS, 3'h0, 14'h0032, 8'h00, 12'h03C);
    hold = 1'b0;
    run(1'b0, 5'h03, '{16'h0014, 16'h0064}, '{4'h1, 4'h2, 4'h4, 4'h0});
    check("last section", section, 5'h02);
    hold = 1'b1;
    foreach (rows[i]) begin
      hold_val = rows[i].act;
      set_pb(1'b0, rows[i].ct, 3'h0, rows[i].band, rows[i].off, 12'h03C);
      check("level", level, rows[i].lvl);
      check("switch one", sw1, rows[i].sw1);
      check("switch two", sw2, rows[i].sw2);
    end
    hold_val = 16'h0064;
    set_pb(1'b1, spp_pkg::SPP_CONTINUOUS, 3'h0, 14'h0032, 8'h1E, 12'h03C);
    pblk_use = 1'b1;
    repeat (3) @(negedge clk);
    check("block two level", level, 8'h1E);
    set_pb(1'b1, spp_pkg::SPP_THREE_STEP, 3'h7, 14'h0032, 8'h00, 12'h002);
    check("travel clamp", pblk.valve_travel_time, 12'h005);
    check("struct clamp", pblk.struct_first, spp_pkg::SPP_PID);
    pblk_use = 1'b0;
    sect_wr = 1'b1;
    sp_max = 16'h0064;
    wsect(5'h00, 16'h0000, 16'h0004, 4'h1);
    wsect(5'h01, 16'h0064, 16'h0002, 4'h3);
    wsect(5'h02, 16'h00C8, 16'h0002, 4'h0);
    sect_wr = 1'b0;
    hold = 1'b0;
    run(1'b1, 5'h03, '{16'h0000, 16'h0019, 16'h0032, 16'h004B, 16'h0064},
        '{4'h1, 4'h3, 4'h0});
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    repeat (6) @(negedge clk);
    stop = 1'b1;
    @(negedge clk);
    stop = 1'b0;
    repeat (2) @(negedge clk);
    check("abort running", running, 1'b0);
    check("abort contacts", contacts, 4'h0);
    check("abort section", section, 5'h00);
    sect_count = 5'h00;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    repeat (4) @(negedge clk);
    check("empty program", running, 1'b0);
    tally_and_finish();
  end

  initial begin
    repeat (40000) @(posedge clk);
    n_fail++;
    tally_and_finish();
  end
endmodule
